// File: bench/i2cm_master_top_properties.sv
// checker: phase lengths, flag side effects and bus-state codes
`include "i2cm_regs.svh"

module i2cm_master_top_properties
	import i2cm_pkg::*;
#(
	parameter int TIMEOUT_CYC = 20
) (
	input wire logic                    ref_clk,   // clock
	input wire logic                    rst,       // reset
	input wire logic [`I2CM_ADDR_W-1:0] reg_addr,  // index
	input wire logic [7:0]              reg_wdata, // write data
	input wire logic                    reg_wr,    // write
	input wire logic                    reg_rd,    // read
	input wire logic [7:0]              reg_rdata, // read data
	input wire logic                    scl_i,     // clock line
	input wire logic                    scl_o,     // unused
	input wire logic                    scl_oe,    // clock pull
	input wire logic                    sda_i,     // data line
	input wire logic                    sda_o,     // unused
	input wire logic                    sda_oe     // data pull
);
	logic       en_r;
	logic       en_d_r;
	logic       st_rd_r;
	logic       off_rd_r;
	logic [7:0] per_r;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// enable and period shadowed from the write strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			en_r  <= 1'h0;
			per_r <= 8'h00;
		end else if (reg_wr && reg_addr == 3'h0) begin
			en_r <= reg_wdata[0];
		end else if (reg_wr && reg_addr == 3'h1) begin
			per_r <= reg_wdata;
		end
	end
	always_ff @(posedge ref_clk) begin
		en_d_r   <= en_r;
		st_rd_r  <= reg_rd && reg_addr == 3'h2;
		off_rd_r <= reg_rd && reg_addr == 3'h2 && !en_r;
	end
	property p_rst_quiet;
		disable iff (1'h0) rst |=> !scl_oe && !sda_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("lines driven after reset");
	property p_low_phase;
		$rose(scl_oe) && per_r == 8'h02 |-> scl_oe[*7];
	endproperty
	a_low_phase: assert property (p_low_phase)
		else $error("low phase too short");
	property p_high_phase;
		$fell(scl_oe) && per_r == 8'h02 |-> !scl_oe[*7];
	endproperty
	a_high_phase: assert property (p_high_phase)
		else $error("high phase too short");
	property p_hold;
		st_rd_r && (reg_rdata[6] || reg_rdata[7]) && !reg_rdata[3] |=> scl_oe;
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag set without clock hold");
	property p_arb_free;
		st_rd_r && reg_rdata[3] |=> !scl_oe && !sda_oe;
	endproperty
	a_arb_free: assert property (p_arb_free)
		else $error("lines driven after lost arbitration");
	property p_err_lost;
		st_rd_r && reg_rdata[2] |-> reg_rdata[3] && reg_rdata[6];
	endproperty
	a_err_lost: assert property (p_err_lost)
		else $error("bus error without lost and write flags");
	property p_off_quiet;
		!en_r && !en_d_r |-> !scl_oe && !sda_oe;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("lines driven while disabled");
	property p_off_unknown;
		off_rd_r |-> reg_rdata[1:0] == 2'h0;
	endproperty
	a_off_unknown: assert property (p_off_unknown)
		else $error("bus state known while disabled");
endmodule : i2cm_master_top_properties

bind i2cm_master_top i2cm_master_top_properties #(.TIMEOUT_CYC(TIMEOUT_CYC))
	u_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// File: bench/i2cm_slave_model.sv
// target on the wire: acks one address and returns one byte
module i2cm_slave_model #(
	parameter logic [6:0] ADDR  = 7'h2a,
	parameter logic [7:0] RDATA = 8'ha5
) (
	input wire logic scl,     // clock line
	input wire logic sda,     // data line
	output logic     sda_low  // pulls data low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       ps;
	logic       pd;
	logic       act;
	logic       hit;
	logic [7:0] sh;
	int         p;
	// polled off the clock grid so a joint edge of both lines never reads
	// as a start or stop
	initial begin
		sda_low = 1'h0;
		act = 1'h0;
		hit = 1'h0;
		sh = 8'h00;
		p = 0;
		ps = 1'h1;
		pd = 1'h1;
		#5;
		forever begin
			if (ps && scl && pd && !sda) begin
				act = 1'h1;
				p = 0;
			end else if (ps && scl && !pd && sda) begin
				act = 1'h0;
				sda_low = 1'h0;
			end else if (act && !ps && scl) begin
				p++;
				if (p <= 8) sh = {sh[6:0], sda};
			end else if (act && ps && !scl) begin
				if (p == 8) begin
					hit = sh[7:1] == ADDR;
					sda_low = hit;
				end else if (p >= 9 && p <= 16 && hit && sh[0]) begin
					sda_low = !RDATA[16-p];
				end else begin
					sda_low = 1'h0;
				end
			end
			ps = scl;
			pd = sda;
			#10;
		end
	end
endmodule : i2cm_slave_model

// File: bench/test_i2cm_master_top.sv
// bench: bus-state tracking, address outcomes and clock hold
module test_i2cm_master_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         TO  = 20;
	localparam logic [6:0] SLV = 7'h2a;
	localparam logic [7:0] RB  = 8'ha5;
	logic       ref_clk = 1'h0;
	logic       rst = 1'h1;
	logic       reg_wr = 1'h0;
	logic       reg_rd = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] st;
	logic       scl_o, scl_oe, sda_o, sda_oe, slv_low;
	logic       x_scl = 1'h0;
	logic       x_sda = 1'h0;
	int         errors = 0;
	int         samples_checked = 0;
	wire        scl = !(scl_oe || x_scl);
	wire        sda = !(sda_oe || slv_low || x_sda);
	i2cm_master_top #(.TIMEOUT_CYC(TO)) u_i2cm_master_top (.ref_clk, .rst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i(scl),
		.scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
	i2cm_slave_model #(.ADDR(SLV), .RDATA(RB)) u_i2cm_slave_model (
		.scl(scl), .sda(sda), .sda_low(slv_low));
	always #20 ref_clk = ~ref_clk;
	task automatic chk(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 st = reg_rdata;
	endtask : rd
	task automatic cs(input logic [7:0] exp);
		rd(3'h2);
		chk("status", exp, st);
	endtask : cs
	task automatic wait_st(input logic [7:0] m, v);
		int n;
		n = 0;
		do begin
			rd(3'h2);
			n++;
		end while ((st & m) !== v && n < 2000);
		// a flag that never comes is a fault, not a silent pass
		if ((st & m) !== v)
			errors++;
	endtask : wait_st
	task automatic wait_oe(input logic v);
		int n;
		n = 0;
		while (scl_oe !== v && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		if (scl_oe !== v)
			errors++;
	endtask : wait_oe
	task automatic ext_sda(input logic low, input int cyc);
		@(posedge ref_clk);
		x_sda <= low;
		repeat (cyc) @(posedge ref_clk);
	endtask : ext_sda
	// another master clocks nine bits, eight of our cycles per bit
	task automatic ext_frame(input logic [7:0] mid, fin);
		ext_sda(1'h1, 10);
		repeat (9) begin
			repeat (4) @(posedge ref_clk);
			x_scl <= 1'h1;
			repeat (4) @(posedge ref_clk);
			x_scl <= 1'h0;
		end
		cs(mid);
		ext_sda(1'h0, 10);
		cs(fin);
	endtask : ext_frame
	task automatic stop_idle(input logic [7:0] exp);
		wr(3'h5, 8'h03);
		wait_st(8'h03, 8'h01);
		cs(exp);
	endtask : stop_idle
	task automatic t_states();
		cs(8'h00);
		rd(3'h6);
		chk("unmapped", 8'h00, st);
		wr(3'h0, 8'h01);
		repeat (3 * TO) @(posedge ref_clk);
		cs(8'h00);
		ext_frame(8'h00, 8'h01);
		ext_frame(8'h03, 8'h01);
		wr(3'h0, 8'h00);
		cs(8'h00);
		wr(3'h0, 8'h01);
		wr(3'h2, 8'h01);
		cs(8'h01);
	endtask : t_states
	task automatic t_timeout();
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h03);
		cs(8'h00);
		repeat (2 * TO) @(posedge ref_clk);
		cs(8'h01);
		ext_sda(1'h1, 8);
		cs(8'h03);
		repeat (2 * TO) @(posedge ref_clk);
		cs(8'h01);
		ext_sda(1'h0, 8);
		wr(3'h0, 8'h01);
	endtask : t_timeout
	// a second master cuts our first high short, then outlasts our low
	task automatic t_sync();
		wait_oe(1'h1);
		wait_oe(1'h0);
		repeat (3) @(posedge ref_clk);
		x_scl <= 1'h1;
		repeat (4) @(posedge ref_clk);
		chk("early low", 8'h01, {7'h00, scl_oe});
		repeat (16) @(posedge ref_clk);
		chk("low wait", 8'h00, {7'h00, scl_oe});
		x_scl <= 1'h0;
	endtask : t_sync
	task automatic t_addr();
		wr(3'h1, 8'h02);
		ext_sda(1'h1, 4);
		wr(3'h3, {SLV, 1'h0});
		repeat (40) @(posedge ref_clk);
		chk("drive", 8'h00, {6'h00, scl_oe, sda_oe});
		ext_sda(1'h0, 1);
		t_sync();
		wait_st(8'h40, 8'h40);
		cs(8'h62);
		chk("hold", 8'h01, {7'h00, scl_oe});
		wr(3'h4, 8'h5a);
		wait_st(8'h40, 8'h40);
		cs(8'h72);
		stop_idle(8'h11);
		wr(3'h3, {7'h11, 1'h0});
		wait_st(8'h40, 8'h40);
		cs(8'h72);
		// repeated start from the hold keeps the bus owned
		wr(3'h3, {SLV, 1'h0});
		wait_st(8'h40, 8'h40);
		cs(8'h62);
		stop_idle(8'h01);
		wr(3'h3, {SLV, 1'h1});
		wait_st(8'h80, 8'h80);
		cs(8'ha2);
		rd(3'h4);
		chk("byte", RB, st);
		stop_idle(8'h01);
	endtask : t_addr
	// lost arbitration; with err set, a foreign start inside our high bit
	task automatic t_lose(input logic err);
		wr(3'h3, {7'h7f, 1'h1});
		wait_oe(1'h1);
		if (err) begin
			wait_oe(1'h0);
			repeat (2) @(posedge ref_clk);
		end
		x_sda <= 1'h1;
		wait_st(8'h40, 8'h40);
		chk("status", err ? 8'h4f : 8'h4b, st & 8'hef);
		chk("drive", 8'h00, {6'h00, scl_oe, sda_oe});
		ext_sda(1'h0, 4);
		wait_st(8'h03, 8'h01);
		wr(3'h2, 8'h4c);
		rd(3'h2);
		chk("status", 8'h01, st & 8'hef);
	endtask : t_lose
	task automatic final_report();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'h0;
		t_states();
		t_timeout();
		t_addr();
		t_lose(1'h0);
		t_lose(1'h1);
		final_report();
	end
	// the whole run needs far fewer cycles than this
	initial begin
		#(40 * 60000);
		errors++;
		final_report();
	end
endmodule : test_i2cm_master_top

// File: pkg/i2cm_pkg.sv
// types for the two-wire master: bus state and transfer engine states
package i2cm_pkg;

	typedef enum logic [1:0] {
		BUS_UNKNOWN = 2'b00,
		BUS_IDLE    = 2'b01,
		BUS_OWNER   = 2'b10,
		BUS_BUSY    = 2'b11
	} i2cm_bus_t;

	typedef enum logic [3:0] {
		E_IDLE     = 4'b0000,
		E_WAIT     = 4'b0001,
		E_START    = 4'b0010,
		E_LOW      = 4'b0011,
		E_WHI      = 4'b0100,
		E_HIGH     = 4'b0101,
		E_HOLD     = 4'b0110,
		E_RS_LOW   = 4'b0111,
		E_RS_HI    = 4'b1000,
		E_STOP_LOW = 4'b1001,
		E_STOP_HI  = 4'b1010,
		E_STOP_END = 4'b1011
	} i2cm_eng_t;

endpackage : i2cm_pkg

// File: pkg/i2cm_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH

`define I2CM_ADDR_W          3
`define I2CM_OFF_CTRL        3'h0
`define I2CM_OFF_PERIOD      3'h1
`define I2CM_OFF_STATUS      3'h2
`define I2CM_OFF_TARGET      3'h3
`define I2CM_OFF_BYTE        3'h4
`define I2CM_OFF_CMD         3'h5

`define I2CM_CTRL_EN         0
`define I2CM_CTRL_TOEN       1
`define I2CM_ST_BUS_LO       0
`define I2CM_ST_BUS_HI       1
`define I2CM_ST_BUS_FAULT_FLAG       2
`define I2CM_ST_LOST_ARBITRATION_FLAG      3
`define I2CM_ST_RECEIVED_ACK_FLAG        4
`define I2CM_ST_CLKHOLD      5
`define I2CM_ST_WIF          6
`define I2CM_ST_RIF          7
`define I2CM_CMD_NACK        2
`define I2CM_CMD_RECV        2'h2
`define I2CM_CMD_STOP        2'h3

`define I2CM_PERIOD_RST      8'h00
`define I2CM_STATUS_RST      8'h00
`define I2CM_BUS_FORCE_IDLE  2'h1
`define I2CM_UNMAPPED_RD     8'h00

`define I2CM_CLK_NS          40
`define I2CM_PHASE_BASE      5
`define I2CM_TIMEOUT_NS      50000
`define I2CM_TIMEOUT_CYC     (`I2CM_TIMEOUT_NS / `I2CM_CLK_NS)

`endif

// File: src/i2cm_master_top.sv
// two-wire bus master: clock sync, bus state monitor, start and address
// Overview of operation
// [RQ1] each seen falling clock edge starts own low timing; then wait for high
// [RQ2] whoever ends its high period first pulls the clock low again
// [RQ3] while enabled, watch lines for start, stop, collision, inactivity
// [RQ4] bus state readable in status: unknown, idle, busy or owner
// [RQ5] reset or enable gives unknown; writing idle code forces idle
// [RQ6] unknown becomes idle on first stop or enabled time-out
// [RQ7] only reset or master disable return a known state to unknown
// [RQ8] idle goes busy on foreign start; busy idles on stop or time-out
// [RQ9] own start while idle makes owner; own stop returns to idle
// [RQ10] collision while owner means arbitration lost; busy until stop
// [RQ11] repeated start changes state only when arbitration lost on it
// [RQ12] write and read flags plus ack, error, lost, hold, state status
// [RQ13] any master flag set holds clock low; clearing flags releases it; here lost flag holds nothing, only target, byte, receive or stop writes end a hold
// [RQ14] software keeps period value within the chosen speed limit
// [RQ15] one period value times high and low: 10 plus twice value cycles
// [RQ16] high timing starts only after the clock line is seen high
// [RQ17] target write sends start and address, waiting for idle first
// [RQ18] lost arbitration: write and lost flags, release lines, wait idle
// [RQ19] bus error in address acts like lost arbitration, plus error flag
// [RQ20] address not acknowledged: write flag, ack flag high, clock held
// [RQ21] write address acknowledged: write flag, ack flag low, clock held
// [RQ22] software should enable the inactive bus time-out
// [RQ23] read address acknowledged: get first byte, read flag, clock held
// [RQ24] byte write clears write flag and sends byte; flag sets on end
// [RQ25] after data nack software sends new target or stop command
// [RQ26] state codes: unknown 00, idle 01, owner 10, busy 11
//
// Our own choices: the plain strobed port and the register offsets.
`include "i2cm_regs.svh"

module i2cm_master_top
	import i2cm_pkg::*;
#(
	parameter int TIMEOUT_CYC = `I2CM_TIMEOUT_CYC
) (
	input  wire logic                    ref_clk,    // 25 MHz clock
	input  wire logic                    rst,        // sync reset, high
	input  wire logic [`I2CM_ADDR_W-1:0] reg_addr,   // register index
	input  wire logic [7:0]              reg_wdata,  // write data
	input  wire logic                    reg_wr,     // write strobe
	input  wire logic                    reg_rd,     // read strobe
	output logic      [7:0]              reg_rdata,  // read data, next cycle
	input  wire logic                    scl_i,      // clock line level
	output logic                         scl_o,      // clock drive value
	output logic                         scl_oe,     // clock line pulled low
	input  wire logic                    sda_i,      // data line level
	output logic                         sda_o,      // data drive value
	output logic                         sda_oe      // data line pulled low
);

	logic [1:0]  scl_sy_r;
	logic [1:0]  sda_sy_r;
	logic        scl_d_r;
	logic        sda_d_r;
	logic        en_r;
	logic        to_en_r;
	logic [7:0]  period_reg_r;
	logic [7:0]  target_r;
	logic [7:0]  rx_byte_r;
	logic        nack_r;
	logic        wif_r;
	logic        rif_r;
	logic        arb_r;
	logic        berr_r;
	logic        received_ack_flag_r;
	i2cm_bus_t   bus_r;
	i2cm_eng_t   eng_r;
	logic [8:0]  cnt_r;
	logic [3:0]  bcnt_r;
	logic [7:0]  sh_r;
	logic        tx_r;
	logic        want_hi_r;
	logic        scl_drv_r;
	logic        sda_drv_r;
	logic [15:0] idle_cnt_r;
	logic [7:0]  rdata_r;

	logic        scl_s;
	logic        sda_s;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic [8:0]  phase_max;
	logic        hi_end;
	logic        in_pkt;
	logic        arb_now;
	logic        berr_now;
	logic        lose;
	logic        ack_done;
	logic        rx_done;
	logic        timeout;
	logic        wr_ctrl;
	logic        wr_status;
	logic        wr_target;
	logic        wr_byte;
	logic        wr_cmd;
	logic        bitval;
	logic        sourced;

	// only the second stage of each synchroniser feeds logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_sy_r <= 2'b11;
			sda_sy_r <= 2'b11;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_sy_r <= {scl_sy_r[0], scl_i};
			sda_sy_r <= {sda_sy_r[0], sda_i};
			scl_d_r  <= scl_sy_r[1];
			sda_d_r  <= sda_sy_r[1];
		end
	end

	assign scl_s     = scl_sy_r[1];
	assign sda_s     = sda_sy_r[1];
	assign scl_fall  = scl_d_r & ~scl_s;                       // [RQ1]
	assign start_det = en_r & scl_s & scl_d_r & sda_d_r & ~sda_s; // [RQ3]
	assign stop_det  = en_r & scl_s & scl_d_r & ~sda_d_r & sda_s; // [RQ3]

	// low and high each last base plus period value cycles
	assign phase_max = 9'(`I2CM_PHASE_BASE - 1) + {1'b0, period_reg_r}; // [RQ15]
	assign hi_end    = (eng_r == E_HIGH) &
		((cnt_r == phase_max) | scl_fall);                       // [RQ2]
	assign in_pkt    = (eng_r == E_LOW) | (eng_r == E_WHI) |
		(eng_r == E_HIGH);
	assign arb_now   = (eng_r == E_HIGH) & want_hi_r & ~sda_s;  // [RQ10]
	assign berr_now  = in_pkt & (start_det | stop_det);         // [RQ19]
	assign lose      = arb_now | berr_now;
	assign ack_done  = hi_end & ~lose & tx_r & (bcnt_r == 4'd8);
	assign rx_done   = hi_end & ~lose & ~tx_r & (bcnt_r == 4'd8);
	assign timeout   = to_en_r & (idle_cnt_r == 16'(TIMEOUT_CYC));

	assign wr_ctrl   = reg_wr & (reg_addr == `I2CM_OFF_CTRL);
	assign wr_status = reg_wr & (reg_addr == `I2CM_OFF_STATUS);
	assign wr_target = reg_wr & (reg_addr == `I2CM_OFF_TARGET) & en_r;
	assign wr_byte   = reg_wr & (reg_addr == `I2CM_OFF_BYTE) & en_r;
	assign wr_cmd    = reg_wr & (reg_addr == `I2CM_OFF_CMD) & en_r;

	// next bit level and whether this master is its source
	always_comb begin
		bitval  = 1'b1;
		sourced = 1'b0;
		if (tx_r && bcnt_r < 4'd8) begin
			bitval  = sh_r[7];
			sourced = 1'b1;
		end else if (!tx_r && bcnt_r == 4'd0) begin
			bitval  = nack_r;
			sourced = 1'b1;
		end
	end

	// software configuration
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			en_r         <= 1'b0;
			to_en_r      <= 1'b0;
			period_reg_r <= `I2CM_PERIOD_RST;
			target_r     <= 8'h00;
			nack_r       <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				en_r    <= reg_wdata[`I2CM_CTRL_EN];
				to_en_r <= reg_wdata[`I2CM_CTRL_TOEN];
			end
			if (reg_wr && reg_addr == `I2CM_OFF_PERIOD)
				period_reg_r <= reg_wdata;
			if (wr_target)
				target_r <= reg_wdata;
			if (wr_cmd)
				nack_r <= reg_wdata[`I2CM_CMD_NACK];
		end
	end

	// inactivity timer: any line change restarts it
	always_ff @(posedge ref_clk) begin
		if (rst || !en_r || scl_s != scl_d_r || sda_s != sda_d_r)
			idle_cnt_r <= 16'h0000;
		else if (!timeout)
			idle_cnt_r <= idle_cnt_r + 16'h0001;
	end

	// bus state; disabling the master forgets the state
	always_ff @(posedge ref_clk) begin
		if (rst || !en_r) begin
			bus_r <= BUS_UNKNOWN;                                  // [RQ5] [RQ7]
		end else if (lose && bus_r == BUS_OWNER) begin
			bus_r <= BUS_BUSY;                                     // [RQ10] [RQ11]
		end else if (wr_status && reg_wdata[`I2CM_ST_BUS_HI:0] ==
			`I2CM_BUS_FORCE_IDLE) begin
			bus_r <= BUS_IDLE;                                     // [RQ5] [RQ26]
		end else begin
			case (bus_r)
			BUS_UNKNOWN: begin
				if (stop_det || timeout)
					bus_r <= BUS_IDLE;                             // [RQ6]
			end
			BUS_IDLE: begin
				if (start_det)
					bus_r <= (eng_r == E_START) ? BUS_OWNER
						: BUS_BUSY;                                // [RQ8] [RQ9]
			end
			BUS_BUSY: begin
				if (stop_det || timeout)
					bus_r <= BUS_IDLE;                             // [RQ8]
			end
			BUS_OWNER: begin
				if (stop_det)
					bus_r <= BUS_IDLE;                             // [RQ9]
			end
			default: bus_r <= BUS_UNKNOWN;
			endcase
		end
	end

	// status flags: hardware set wins over a software clear
	always_ff @(posedge ref_clk) begin
		if (rst || !en_r) begin
			wif_r   <= 1'b0;
			rif_r   <= 1'b0;
			arb_r   <= 1'b0;
			berr_r  <= 1'b0;
			received_ack_flag_r <= 1'b0;
		end else begin
			if (wr_target || wr_byte || wr_cmd) begin
				wif_r <= 1'b0;                                     // [RQ24]
				rif_r <= 1'b0;
			end
			if (wr_target) begin
				arb_r  <= 1'b0;
				berr_r <= 1'b0;
			end
			if (wr_status) begin
				if (reg_wdata[`I2CM_ST_WIF])
					wif_r <= 1'b0;
				if (reg_wdata[`I2CM_ST_RIF])
					rif_r <= 1'b0;
				if (reg_wdata[`I2CM_ST_LOST_ARBITRATION_FLAG])
					arb_r <= 1'b0;
				if (reg_wdata[`I2CM_ST_BUS_FAULT_FLAG])
					berr_r <= 1'b0;
			end
			if (lose) begin
				wif_r <= 1'b1;                                     // [RQ18]
				arb_r <= 1'b1;                                     // [RQ18]
			end
			if (berr_now)
				berr_r <= 1'b1;                                    // [RQ19]
			if (ack_done) begin
				received_ack_flag_r <= sda_s;                                  // [RQ20] [RQ21]
				// a read address that is acked goes on to the first byte
				if (sda_s || !target_r[0])
					wif_r <= 1'b1;                                 // [RQ20] [RQ21] [RQ24]
			end
			if (rx_done) begin
				rif_r   <= 1'b1;                                   // [RQ23]
				received_ack_flag_r <= 1'b0;                                   // [RQ23]
			end
		end
	end

	// received data byte
	always_ff @(posedge ref_clk) begin
		if (rst)
			rx_byte_r <= 8'h00;
		else if (rx_done)
			rx_byte_r <= {sh_r[6:0], sda_s};
	end

	// transfer engine: drives the lines, times every phase
	always_ff @(posedge ref_clk) begin
		if (rst || !en_r) begin
			eng_r     <= E_IDLE;
			cnt_r     <= 9'h000;
			bcnt_r    <= 4'h0;
			sh_r      <= 8'h00;
			tx_r      <= 1'b1;
			want_hi_r <= 1'b0;
			scl_drv_r <= 1'b0;
			sda_drv_r <= 1'b0;
		end else if (lose) begin
			eng_r     <= E_IDLE;                                   // [RQ18] [RQ19]
			scl_drv_r <= 1'b0;
			sda_drv_r <= 1'b0;
			want_hi_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 9'h001;
			case (eng_r)
			E_IDLE: begin
				if (wr_target) begin
					eng_r <= E_WAIT;                               // [RQ17]
				end
			end
			E_WAIT: begin
				// no bus activity until the state reads idle again
				cnt_r <= 9'h000;
				if (bus_r == BUS_IDLE && scl_s && sda_s)
					eng_r <= E_START;                              // [RQ17] [RQ18]
			end
			E_START: begin
				sda_drv_r <= 1'b1;
				if (!scl_s)
					cnt_r <= 9'h000;
				if (cnt_r == phase_max) begin
					eng_r     <= E_LOW;
					cnt_r     <= 9'h000;
					scl_drv_r <= 1'b1;
					sh_r      <= target_r;
					tx_r      <= 1'b1;
					bcnt_r    <= 4'h0;
				end
			end
			E_LOW: begin
				scl_drv_r <= 1'b1;
				if (cnt_r == 9'h000) begin
					sda_drv_r <= ~bitval;
					want_hi_r <= bitval & sourced;
				end
				if (cnt_r == phase_max) begin
					eng_r     <= E_WHI;                            // [RQ1]
					scl_drv_r <= 1'b0;
				end
			end
			E_WHI: begin
				// rise time stretches the period, it is not absorbed
				cnt_r <= 9'h000;
				if (scl_s)
					eng_r <= E_HIGH;                               // [RQ16]
			end
			E_HIGH: begin
				if (hi_end) begin
					cnt_r     <= 9'h000;
					scl_drv_r <= 1'b1;                             // [RQ2]
					want_hi_r <= 1'b0;
					bcnt_r    <= bcnt_r + 4'h1;
					if (bcnt_r != 4'd8) begin
						eng_r <= E_LOW;
						if (tx_r)
							sh_r <= {sh_r[6:0], 1'b0};
						else if (bcnt_r != 4'd0)
							sh_r <= {sh_r[6:0], sda_s};
					end else if (tx_r && !sda_s && target_r[0] &&
						eng_r == E_HIGH && sh_r == 8'h00 &&
						bcnt_r == 4'd8) begin
						eng_r  <= E_LOW;                           // [RQ23]
						tx_r   <= 1'b0;
						bcnt_r <= 4'h1;
					end else begin
						eng_r <= E_HOLD;                           // [RQ13]
					end
				end
			end
			E_HOLD: begin
				cnt_r     <= 9'h000;
				scl_drv_r <= 1'b1;                                 // [RQ13]
				if (wr_target) begin
					eng_r <= E_RS_LOW;
				end else if (wr_byte) begin
					eng_r  <= E_LOW;                               // [RQ24]
					sh_r   <= reg_wdata;
					tx_r   <= 1'b1;
					bcnt_r <= 4'h0;
				end else if (wr_cmd && reg_wdata[1:0] == `I2CM_CMD_RECV) begin
					eng_r  <= E_LOW;
					tx_r   <= 1'b0;
					bcnt_r <= 4'h0;
				end else if (wr_cmd && reg_wdata[1:0] == `I2CM_CMD_STOP) begin
					eng_r <= E_STOP_LOW;                           // [RQ25]
				end
			end
			E_RS_LOW: begin
				sda_drv_r <= 1'b0;
				if (cnt_r == phase_max) begin
					eng_r     <= E_RS_HI;
					scl_drv_r <= 1'b0;
					cnt_r     <= 9'h000;
				end
			end
			E_RS_HI: begin
				if (!scl_s)
					cnt_r <= 9'h000;                               // [RQ16]
				if (cnt_r == phase_max) begin
					eng_r <= E_START;                              // [RQ11]
					cnt_r <= 9'h000;
				end
			end
			E_STOP_LOW: begin
				sda_drv_r <= 1'b1;
				if (cnt_r == phase_max) begin
					eng_r     <= E_STOP_HI;
					scl_drv_r <= 1'b0;
					cnt_r     <= 9'h000;
				end
			end
			E_STOP_HI: begin
				if (!scl_s)
					cnt_r <= 9'h000;
				if (cnt_r == phase_max) begin
					eng_r     <= E_STOP_END;
					sda_drv_r <= 1'b0;                             // [RQ9]
					cnt_r     <= 9'h000;
				end
			end
			E_STOP_END: begin
				if (cnt_r == phase_max)
					eng_r <= E_IDLE;
			end
			default: eng_r <= E_IDLE;
			endcase
		end
	end

	// read port: data stand in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`I2CM_OFF_CTRL:   rdata_r <= {6'h00, to_en_r, en_r};
			`I2CM_OFF_PERIOD: rdata_r <= period_reg_r;
			`I2CM_OFF_STATUS: rdata_r <= {rif_r, wif_r,
				eng_r == E_HOLD, received_ack_flag_r, arb_r, berr_r, bus_r}; // [RQ4] [RQ12]
			`I2CM_OFF_TARGET: rdata_r <= target_r;
			`I2CM_OFF_BYTE:   rdata_r <= rx_byte_r;
			default:          rdata_r <= `I2CM_UNMAPPED_RD;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = rdata_r;
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = scl_drv_r;
	assign sda_oe    = sda_drv_r;

endmodule : i2cm_master_top
